// >>> eci_pkg.sv
// constants, encodings and carrier types for the ecc injection control block
// Contract
// - The inject control register holds one field per protected RAM, each set by software to none, single-bit or double-bit.
// - With the regfile field armed, the next write to any register except the zero_register is stored with the corruption.
// - After its one injection an armed field returns to no_injection, and a later read shows that value.
// - A corrupted register read through the first operand port raises the ecc error, and the second port also detects it.
// - With the tag field armed, a store hitting a clean line injects the error into the tag write that sets the dirty bit.
// - After a tag injection, a later load or store to the same line detects the bad tag and raises the ecc error.
// - With the data field armed and a clean line resident, a load to that line injects, and a later load detects it.
// - A dirty line corrupted by a store raises on a later load, or some instructions later if found only at writeback.
// - The victim buffer has its own field, and when armed a store into a cached line corrupts the buffered data.
// - With a chosen data_tight_memory field armed, a word_store_op into it is written corrupted and a later load raises.
// - With the translation field armed, a software entry write is corrupted and a matching micro_translation_cache entry may flush.
// - A hardware read of a corrupted translation entry is detected and raised on the first instruction after that read.
// - A software translation read that meets a corrupted entry sets translation_ecc_error_flag to 1 while checking is on.
// - An ecc error exception is raised when an unrecoverable ecc error is detected in a protected RAM while checking is on.
// - Checking is off after reset, while check bits keep being written so checking can be re-enabled freely.
package eci_pkg;

  // ==========================================================
  // register port
  localparam int ECI_ADDR_W = 8;
  localparam int ECI_DATA_W = 32;
  localparam logic [7:0] ECI_OFS_INJECT_CTRL = 8'h00;
  localparam logic [7:0] ECI_OFS_CONFIG = 8'h04;
  localparam logic [7:0] ECI_OFS_TRANS_AUX = 8'h08;
  localparam logic [7:0] ECI_OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ECI_OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ECI_OFS_IRQ_ENABLE = 8'h14;

  // ==========================================================
  // injection fields
  localparam int ECI_FLD_W = 2;
  localparam logic [1:0] ECI_NO_INJECTION = 2'h0;
  localparam logic [1:0] ECI_INJECT_SINGLE_BIT = 2'h1;
  localparam logic [1:0] ECI_INJECT_DOUBLE_BIT = 2'h2;
  localparam logic [1:0] ECI_FIELD_RST = ECI_NO_INJECTION;
  localparam logic [1:0] ECI_FLIP_SINGLE = 2'h1;
  localparam logic [1:0] ECI_FLIP_DOUBLE = 2'h3;
  localparam int ECI_IDX_REGFILE = 0;
  localparam int ECI_IDX_DTAG = 1;
  localparam int ECI_IDX_DDATA = 2;
  localparam int ECI_IDX_VICTIM = 3;
  localparam int ECI_IDX_TLB = 4;
  localparam int ECI_IDX_DTCM0 = 5;

  // ==========================================================
  // config, translation aux and interrupt fields
  localparam int ECI_CFG_ECC_EN_BIT = 0;
  localparam logic ECI_CFG_ECC_EN_RST = 1'b0;
  localparam int ECI_AUX_RD_BIT = 0;
  localparam int ECI_AUX_EE_BIT = 1;
  localparam logic ECI_AUX_EE_RST = 1'b0;
  localparam int ECI_ST_W = 4;
  localparam int ECI_ST_UNCORR = 0;
  localparam int ECI_ST_CORR = 1;
  localparam int ECI_ST_TLB_EE = 2;
  localparam int ECI_ST_INJ_DONE = 3;
  localparam logic [3:0] ECI_STATUS_RST = 4'h0;
  localparam logic [3:0] ECI_ENABLE_RST = 4'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ECI_ADDR_W-1:0] addr;
    logic [ECI_DATA_W-1:0] wdata;
  } eci_bus_s;

endpackage

// >>> eci_slot.sv
// one injection field with its self-disarm and check-bit flip mask
`timescale 1ns/1ps
module eci_slot #(
  parameter int CHK_W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [eci_pkg::ECI_FLD_W-1:0] i_load_val,
  input wire logic i_fire,
  output logic [eci_pkg::ECI_FLD_W-1:0] o_field,
  output logic [CHK_W-1:0] o_flip
);
  import eci_pkg::*;

  typedef struct packed {
    logic [ECI_FLD_W-1:0] field;
    logic [CHK_W-1:0] flip;
  } eci_slot_s;

  eci_slot_s st;
  eci_slot_s next_st;
  logic armed;

  if (CHK_W < 2) begin : g_bad_width
    $error("eci_slot: CHK_W must be at least 2");
  end

  always_comb begin
    next_st = st;
    armed = (st.field == ECI_INJECT_SINGLE_BIT) ||
            (st.field == ECI_INJECT_DOUBLE_BIT);
    next_st.flip = '0;
    if (i_fire && armed) begin
      next_st.field = ECI_NO_INJECTION;
      if (st.field == ECI_INJECT_DOUBLE_BIT) begin
        next_st.flip = CHK_W'(ECI_FLIP_DOUBLE);
      end else begin
        next_st.flip = CHK_W'(ECI_FLIP_SINGLE);
      end
    end
    // a fresh arm from software outranks the disarm
    if (i_load) begin
      if ((i_load_val == ECI_INJECT_SINGLE_BIT) ||
          (i_load_val == ECI_INJECT_DOUBLE_BIT)) begin
        next_st.field = i_load_val;
      end else begin
        next_st.field = ECI_NO_INJECTION;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st <= '{field: ECI_FIELD_RST, flip: '0};
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_field = st.field;
  assign o_flip = st.flip;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  slot_disarm_a: assert property (i_ce && i_fire && armed && !i_load
    |=> o_field == ECI_NO_INJECTION) else $error("field not disarmed");
  flip_single_a: assert property (i_ce && i_fire &&
    o_field == ECI_INJECT_SINGLE_BIT |=> o_flip == CHK_W'(ECI_FLIP_SINGLE))
    else $error("single flip mask wrong");
  flip_double_a: assert property (i_ce && i_fire &&
    o_field == ECI_INJECT_DOUBLE_BIT |=> o_flip == CHK_W'(ECI_FLIP_DOUBLE))
    else $error("double flip mask wrong");
  flip_idle_a: assert property (i_ce && !(i_fire && armed)
    |=> o_flip == '0) else $error("flip without armed write");

endmodule // eci_slot

// >>> eci_ecc_inject.sv
// ecc injection control: field register, write qualifiers, error reporting
`timescale 1ns/1ps
module eci_ecc_inject #(
  parameter int NUM_DATA_TIGHT_MEMORY = 2,
  parameter int CHK_W = 8,
  parameter int RF_AW = 5,
  localparam int NUM_SRC = eci_pkg::ECI_IDX_DTCM0 + NUM_DATA_TIGHT_MEMORY
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // register port
  input wire eci_pkg::eci_bus_s i_bus,
  output logic [eci_pkg::ECI_DATA_W-1:0] o_rdata,
  // write qualifiers from the pipeline
  input wire logic i_rf_wr,
  input wire logic [RF_AW-1:0] i_rf_waddr,
  input wire logic i_dc_store_hit,
  input wire logic i_dc_load_hit,
  input wire logic i_dc_line_clean,
  input wire logic [NUM_DATA_TIGHT_MEMORY-1:0] i_data_tight_memory_word_store,
  input wire logic i_tlb_entry_wr,
  // decoder results
  input wire logic [NUM_SRC-1:0] i_det_uncorr,
  input wire logic [NUM_SRC-1:0] i_det_corr,
  input wire logic i_wb_uncorr,
  input wire logic i_tlb_rd_done,
  input wire logic i_tlb_rd_err,
  // results
  output logic [NUM_SRC-1:0][CHK_W-1:0] o_chk_flip,
  output logic o_ecc_en,
  output logic o_ecc_exc,
  output logic [NUM_SRC-1:0] o_ecc_exc_src,
  output logic o_tlb_rd_req,
  output logic o_micro_translation_cache_flush,
  output logic o_irq
);
  import eci_pkg::*;

  // ==========================================================
  // elaboration checks
  if (NUM_DATA_TIGHT_MEMORY < 1 || NUM_SRC * ECI_FLD_W > ECI_DATA_W) begin : g_bad_data_tight_memory
    $error("eci_ecc_inject: NUM_DATA_TIGHT_MEMORY out of range");
  end
  if (CHK_W < 2 || RF_AW < 1) begin : g_bad_width
    $error("eci_ecc_inject: CHK_W or RF_AW too small");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic ecc_en;
    logic ee;
    logic [ECI_ST_W-1:0] status;
    logic [ECI_ST_W-1:0] enable;
    logic [ECI_DATA_W-1:0] rdata;
    logic exc;
    logic [NUM_SRC-1:0] exc_src;
    logic tlb_rd_req;
    logic micro_translation_cache_flush;
    logic irq;
  } eci_state_s;

  eci_state_s st;
  eci_state_s next_st;

  logic [NUM_SRC-1:0] fire;
  logic [NUM_SRC-1:0] armed;
  logic [NUM_SRC-1:0][ECI_FLD_W-1:0] field;
  logic ctrl_wr;
  logic [NUM_SRC-1:0] uncorr_src;

  // ==========================================================
  // qualifying writes per protected RAM
  always_comb begin
    fire = '0;
    fire[ECI_IDX_REGFILE] = i_rf_wr && (i_rf_waddr != '0);
    fire[ECI_IDX_DTAG] = i_dc_store_hit && i_dc_line_clean;
    // clean-line load, or store that dirties the line
    fire[ECI_IDX_DDATA] = (i_dc_load_hit && i_dc_line_clean) ||
                          i_dc_store_hit;
    fire[ECI_IDX_VICTIM] = i_dc_store_hit;
    fire[ECI_IDX_TLB] = i_tlb_entry_wr;
    for (int k = 0; k < NUM_DATA_TIGHT_MEMORY; k++) begin
      fire[ECI_IDX_DTCM0 + k] = i_data_tight_memory_word_store[k];
    end
  end

  assign ctrl_wr = i_bus.wr && (i_bus.addr == ECI_OFS_INJECT_CTRL);

  // ==========================================================
  // one field per protected RAM
  for (genvar g = 0; g < NUM_SRC; g++) begin : g_slot
    eci_slot #(
      .CHK_W(CHK_W)
    ) u_slot (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_load(ctrl_wr),
      .i_load_val(i_bus.wdata[g*ECI_FLD_W +: ECI_FLD_W]),
      .i_fire(fire[g]),
      .o_field(field[g]),
      .o_flip(o_chk_flip[g])
    );
    assign armed[g] = (field[g] == ECI_INJECT_SINGLE_BIT) ||
                      (field[g] == ECI_INJECT_DOUBLE_BIT);
  end

  // ==========================================================
  // reporting and registers
  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    next_st.tlb_rd_req = 1'b0;
    next_st.exc = 1'b0;
    next_st.exc_src = '0;
    // dirty writeback errors belong to the data and victim RAMs
    uncorr_src = i_det_uncorr;
    if (i_wb_uncorr) begin
      uncorr_src[ECI_IDX_DDATA] = 1'b1;
      uncorr_src[ECI_IDX_VICTIM] = 1'b1;
    end

    // exception only while checking is on; check bits are still written
    if (st.ecc_en && (|uncorr_src)) begin
      next_st.exc = 1'b1;
      next_st.exc_src = uncorr_src;
    end

    // corrupt translation write also drops the cached copy
    next_st.micro_translation_cache_flush = fire[ECI_IDX_TLB] && armed[ECI_IDX_TLB];

    // register writes; clears go first so that sets win
    if (i_bus.wr) begin
      case (i_bus.addr)
        ECI_OFS_CONFIG: begin
          next_st.ecc_en = i_bus.wdata[ECI_CFG_ECC_EN_BIT];
        end
        ECI_OFS_TRANS_AUX: begin
          next_st.tlb_rd_req = i_bus.wdata[ECI_AUX_RD_BIT];
          if (i_bus.wdata[ECI_AUX_EE_BIT]) begin
            next_st.ee = 1'b0;
          end
        end
        ECI_OFS_IRQ_CLEAR: begin
          next_st.status = st.status & ~i_bus.wdata[ECI_ST_W-1:0];
        end
        ECI_OFS_IRQ_ENABLE: begin
          next_st.enable = i_bus.wdata[ECI_ST_W-1:0];
        end
        default: begin
        end
      endcase
    end

    if (st.ecc_en && i_tlb_rd_done && i_tlb_rd_err) begin
      next_st.ee = 1'b1;
      next_st.status[ECI_ST_TLB_EE] = 1'b1;
    end
    if (st.ecc_en && (|uncorr_src)) begin
      next_st.status[ECI_ST_UNCORR] = 1'b1;
    end
    if (st.ecc_en && (|i_det_corr)) begin
      next_st.status[ECI_ST_CORR] = 1'b1;
    end
    if (|(fire & armed)) begin
      next_st.status[ECI_ST_INJ_DONE] = 1'b1;
    end
    next_st.irq = |(next_st.status & next_st.enable);

    // read data in the cycle after the strobe only
    if (i_bus.rd) begin
      case (i_bus.addr)
        ECI_OFS_INJECT_CTRL: begin
          next_st.rdata = ECI_DATA_W'(field);
        end
        ECI_OFS_CONFIG: begin
          next_st.rdata[ECI_CFG_ECC_EN_BIT] = st.ecc_en;
        end
        ECI_OFS_TRANS_AUX: begin
          next_st.rdata[ECI_AUX_EE_BIT] = st.ee;
        end
        ECI_OFS_IRQ_STATUS: begin
          next_st.rdata = ECI_DATA_W'(st.status);
        end
        ECI_OFS_IRQ_ENABLE: begin
          next_st.rdata = ECI_DATA_W'(st.enable);
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st <= '{
        ecc_en: ECI_CFG_ECC_EN_RST,
        ee: ECI_AUX_EE_RST,
        status: ECI_STATUS_RST,
        enable: ECI_ENABLE_RST,
        rdata: '0,
        exc: 1'b0,
        exc_src: '0,
        tlb_rd_req: 1'b0,
        micro_translation_cache_flush: 1'b0,
        irq: 1'b0
      };
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_ecc_en = st.ecc_en;
  assign o_ecc_exc = st.exc;
  assign o_ecc_exc_src = st.exc_src;
  assign o_tlb_rd_req = st.tlb_rd_req;
  assign o_micro_translation_cache_flush = st.micro_translation_cache_flush;
  assign o_irq = st.irq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  rf_zero_skip_a: assert property (i_ce && i_rf_wr && i_rf_waddr == '0
    |=> o_chk_flip[ECI_IDX_REGFILE] == '0)
    else $error("zero register write was corrupted");
  rf_inject_a: assert property (i_ce && fire[ECI_IDX_REGFILE] &&
    armed[ECI_IDX_REGFILE] && !ctrl_wr
    |=> o_chk_flip[ECI_IDX_REGFILE] != '0 &&
        field[ECI_IDX_REGFILE] == ECI_NO_INJECTION)
    else $error("regfile injection missed");
  tag_clean_only_a: assert property (i_ce && i_dc_store_hit &&
    !i_dc_line_clean |=> o_chk_flip[ECI_IDX_DTAG] == '0)
    else $error("tag injected on dirty line");
  ctrl_readback_a: assert property (i_ce && i_bus.rd &&
    i_bus.addr == ECI_OFS_INJECT_CTRL && !ctrl_wr && fire == '0
    |=> o_rdata == ECI_DATA_W'($past(field)))
    else $error("control readback differs");
  exc_raise_a: assert property (i_ce && o_ecc_en && (|i_det_uncorr)
    |=> o_ecc_exc && (o_ecc_exc_src & $past(i_det_uncorr)) != '0)
    else $error("unrecoverable error not raised");
  exc_off_a: assert property (i_ce && !o_ecc_en |=> !o_ecc_exc)
    else $error("exception while checking off");
  wb_raise_a: assert property (i_ce && o_ecc_en && i_wb_uncorr
    |=> o_ecc_exc_src[ECI_IDX_DDATA]) else $error("writeback lost");
  ee_set_a: assert property (i_ce && o_ecc_en && i_tlb_rd_done &&
    i_tlb_rd_err |=> st.ee) else $error("translation flag not set");
  micro_translation_cache_flush_a: assert property (i_ce && i_tlb_entry_wr &&
    armed[ECI_IDX_TLB] |=> o_micro_translation_cache_flush &&
    o_chk_flip[ECI_IDX_TLB] != '0) else $error("tlb inject wrong");
  rdata_idle_a: assert property (i_ce && !i_bus.rd |=> o_rdata == '0)
    else $error("read data outside read slot");
  irq_level_a: assert property (o_irq == |(st.status & st.enable))
    else $error("interrupt level mismatch");

  rf_inject_c: cover property (i_ce && fire[ECI_IDX_REGFILE] &&
    armed[ECI_IDX_REGFILE] ##[1:20] o_ecc_exc);
  data_tight_memory_inject_c: cover property (i_ce && fire[ECI_IDX_DTCM0] &&
    armed[ECI_IDX_DTCM0]);
  ee_set_c: cover property (i_ce && o_ecc_en && i_tlb_rd_done &&
    i_tlb_rd_err);
  irq_c: cover property (o_irq ##1 !o_irq);

endmodule // eci_ecc_inject

// >>> eci_note_unused_guard.sv
// intentionally left empty
`timescale 1ns/1ps

// >>> tb_top.sv
// self-checking testbench for the ecc injection control block
`timescale 1ns/1ps
module tb_top;
  import eci_pkg::*;
  // ==========================================================
  // signals
  logic clk, rst, ce, rf_wr, st_hit, ld_hit, clean, tlb_wr, wb_u;
  logic rd_done, rd_err, ecc_en, exc, rd_req, micro_translation_cache_flush, irq;
  logic [4:0] rf_waddr;
  logic [1:0] tcm_st;
  logic [6:0] det_u, det_c, exc_src;
  logic [6:0][7:0] flip;
  logic [31:0] rdata, d;
  eci_bus_s bus;
  int fails, tests_run, cycles;

  eci_ecc_inject #(.NUM_DATA_TIGHT_MEMORY(2), .CHK_W(8), .RF_AW(5)) uut (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_bus(bus), .o_rdata(rdata),
    .i_rf_wr(rf_wr), .i_rf_waddr(rf_waddr), .i_dc_store_hit(st_hit),
    .i_dc_load_hit(ld_hit), .i_dc_line_clean(clean),
    .i_data_tight_memory_word_store(tcm_st), .i_tlb_entry_wr(tlb_wr),
    .i_det_uncorr(det_u), .i_det_corr(det_c), .i_wb_uncorr(wb_u),
    .i_tlb_rd_done(rd_done), .i_tlb_rd_err(rd_err), .o_chk_flip(flip),
    .o_ecc_en(ecc_en), .o_ecc_exc(exc), .o_ecc_exc_src(exc_src),
    .o_tlb_rd_req(rd_req), .o_micro_translation_cache_flush(micro_translation_cache_flush), .o_irq(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  task automatic give_verdict();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string msg);
    tests_run++;
    if (got !== exp) begin
      $display("Error t=%0t %s got %0h exp %0h", $time, msg, got, exp);
      fails++;
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] rd);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 rd = rdata;
  endtask

  task automatic set_q(input int i, input logic v);
    case (i)
      0: begin rf_wr <= v; rf_waddr <= 5'h03; end
      1: begin st_hit <= v; clean <= v; end
      2: begin ld_hit <= v; clean <= v; end
      3: st_hit <= v;
      4: tlb_wr <= v;
      default: tcm_st[i-5] <= v;
    endcase
  endtask

  task automatic qual(input int i);
    @(posedge clk);
    set_q(i, 1'b1);
    @(posedge clk);
    set_q(i, 1'b0);
    #1;
  endtask

  task automatic ev(input logic [6:0] u, input logic [6:0] c,
                    input logic wb);
    @(posedge clk);
    det_u <= u;
    det_c <= c;
    wb_u <= wb;
    @(posedge clk);
    det_u <= 7'h00;
    det_c <= 7'h00;
    wb_u <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    bus_rd(ECI_OFS_INJECT_CTRL, d);
    chk(d, 64'h0, "ctrl reset");
    bus_rd(ECI_OFS_CONFIG, d);
    chk(d, 64'h0, "config reset");
    chk(ecc_en, 64'h0, "checking off");
    bus_rd(8'h20, d);
    chk(d, 64'h0, "unmapped read");
  endtask

  task automatic t_regfile();
    bus_wr(ECI_OFS_INJECT_CTRL, 32'h3);
    bus_rd(ECI_OFS_INJECT_CTRL, d);
    chk(d, 64'h0, "reserved code");
    bus_wr(ECI_OFS_INJECT_CTRL, 32'h1);
    @(posedge clk);
    rf_wr <= 1'b1;
    rf_waddr <= 5'h00;
    @(posedge clk);
    rf_wr <= 1'b0;
    #1 chk(flip, 64'h0, "zero register write");
    bus_rd(ECI_OFS_INJECT_CTRL, d);
    chk(d, 64'h1, "still armed");
    qual(0);
    chk(flip, 64'h1, "regfile single");
    bus_rd(ECI_OFS_INJECT_CTRL, d);
    chk(d, 64'h0, "regfile disarm");
  endtask

  task automatic t_fields();
    for (int i = 0; i < 7; i++) begin
      bus_wr(ECI_OFS_INJECT_CTRL, 32'h2 << (2 * i));
      bus_rd(ECI_OFS_INJECT_CTRL, d);
      chk(d, 64'h2 << (2 * i), "field armed");
      qual(i);
      chk(flip, 64'h3 << (8 * i), "double flip");
      chk(micro_translation_cache_flush, (i == 4), "micro_translation_cache flush");
      bus_rd(ECI_OFS_INJECT_CTRL, d);
      chk(d, 64'h0, "field disarm");
    end
  endtask

  task automatic t_tag_dirty();
    bus_wr(ECI_OFS_INJECT_CTRL, 32'h4);
    @(posedge clk);
    st_hit <= 1'b1;
    @(posedge clk);
    st_hit <= 1'b0;
    #1 chk(flip, 64'h0, "dirty line store");
    bus_rd(ECI_OFS_INJECT_CTRL, d);
    chk(d, 64'h4, "tag still armed");
    qual(1);
    chk(flip, 64'h100, "tag single");
  endtask

  task automatic t_detect();
    ev(7'h02, 7'h00, 1'b0);
    chk(exc, 64'h0, "checking off no exc");
    bus_wr(ECI_OFS_CONFIG, 32'h1);
    bus_wr(ECI_OFS_IRQ_ENABLE, 32'h1);
    chk(ecc_en, 64'h1, "checking on");
    ev(7'h02, 7'h00, 1'b0);
    chk({exc, exc_src}, {1'b1, 7'h02}, "tag exc");
    chk(irq, 64'h1, "irq raised");
    @(posedge clk);
    #1 chk(exc, 64'h0, "exc one cycle");
    bus_rd(ECI_OFS_IRQ_STATUS, d);
    chk(d, 64'h9, "status sticky");
    bus_wr(ECI_OFS_IRQ_CLEAR, 32'hF);
    #1 bus_rd(ECI_OFS_IRQ_STATUS, d);
    chk({irq, d}, 64'h0, "status cleared");
    ev(7'h01, 7'h00, 1'b0);
    chk({exc, exc_src}, {1'b1, 7'h01}, "regfile exc");
    ev(7'h00, 7'h00, 1'b1);
    chk({exc, exc_src}, {1'b1, 7'h0C}, "writeback exc");
    bus_wr(ECI_OFS_IRQ_CLEAR, 32'hF);
    ev(7'h00, 7'h04, 1'b0);
    chk({exc, irq}, 64'h0, "corr no exc masked");
    bus_rd(ECI_OFS_IRQ_STATUS, d);
    chk(d, 64'h2, "corr status");
    bus_wr(ECI_OFS_IRQ_CLEAR, 32'hF);
    // clock enable low: an error pulse must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    det_u <= 7'h01;
    @(posedge clk);
    det_u <= 7'h00;
    ce <= 1'b1;
    #1 chk(exc, 64'h0, "frozen by enable");
    bus_rd(ECI_OFS_IRQ_STATUS, d);
    chk(d, 64'h0, "status frozen");
  endtask

  task automatic t_tlb();
    bus_wr(ECI_OFS_TRANS_AUX, 32'h1);
    #1 chk(rd_req, 64'h1, "read request");
    @(posedge clk);
    rd_done <= 1'b1;
    rd_err <= 1'b1;
    @(posedge clk);
    rd_done <= 1'b0;
    rd_err <= 1'b0;
    bus_rd(ECI_OFS_TRANS_AUX, d);
    chk(d & 32'h2, 64'h2, "ee flag set");
    bus_rd(ECI_OFS_IRQ_STATUS, d);
    chk(d & 32'h4, 64'h4, "ee status");
    bus_wr(ECI_OFS_TRANS_AUX, 32'h2);
    bus_rd(ECI_OFS_TRANS_AUX, d);
    chk(d & 32'h2, 64'h0, "ee flag clear");
  endtask

  // ==========================================================
  // timeout and main sequence
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    fails = 0;
    tests_run = 0;
    cycles = 0;
    rst = 1'b1;
    ce = 1'b1;
    bus = '0;
    {rf_wr, st_hit, ld_hit, clean, tlb_wr, wb_u, rd_done, rd_err} = '0;
    rf_waddr = 5'h00;
    tcm_st = 2'h0;
    det_u = 7'h00;
    det_c = 7'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regfile();
    t_fields();
    t_tag_dirty();
    t_detect();
    t_tlb();
    give_verdict();
  end
endmodule // tb_top
